// File: tb/bcs_top_asserts.sv
// Port checker for the branch condition select block
`timescale 1ns/10ps
module bcs_chk (
  input wire pclk,
  input wire presetn,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire [7:0] paddr,
  input wire [2:0] cr_group_bits,
  input wire [3:0] cr_cond_pos,
  input wire index_test,
  input wire macro_irq_n,
  input wire alu_c,
  input wire first_ucycle,
  input wire conv_sel_hi,
  input wire conv_sel_lo,
  input wire branch_cond
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire g = &cr_group_bits; // Group select
  wire [3:0] q = cr_cond_pos; // Position
  AST_IDX: assert property (!g && q == 4'h0 |-> branch_cond == index_test)
    else $error("index position wrong");
  AST_ONE: assert property (!g && q == 4'h3 |-> branch_cond)
    else $error("constant one wrong");
  AST_IRQ: assert property (!g && q == 4'hC |-> branch_cond == macro_irq_n)
    else $error("interrupt position wrong");
  AST_LOW: assert property (g && q == 4'h4 |-> !branch_cond)
    else $error("constant zero wrong");
  AST_CARRY: assert property (g && q == 4'h5 |-> branch_cond == alu_c)
    else $error("carry code wrong");
  AST_HOLD: assert property (!$past(first_ucycle) |-> $stable({conv_sel_hi, conv_sel_lo}))
    else $error("conversion select moved");
  AST_WAIT: assert property ($rose(penable) |-> !pready ##1 pready)
    else $error("no answer after one wait");
  AST_ERR: assert property (pready && paddr > 8'h0C |-> pslverr)
    else $error("unmapped access not refused");
  AST_COV_ERR: cover property (pready && pslverr);
  AST_COV_LOAD: cover property (first_ucycle);
  AST_COV_GRP: cover property (g);
endmodule
bind bcs_top bcs_chk u_chk (
  .pclk(pclk),
  .presetn(presetn),
  .penable(penable),
  .pready(pready),
  .pslverr(pslverr),
  .paddr(paddr),
  .cr_group_bits(cr_group_bits),
  .cr_cond_pos(cr_cond_pos),
  .index_test(index_test),
  .macro_irq_n(macro_irq_n),
  .alu_c(alu_c),
  .first_ucycle(first_ucycle),
  .conv_sel_hi(conv_sel_hi),
  .conv_sel_lo(conv_sel_lo),
  .branch_cond(branch_cond)
);

// File: tb/bcs_useq.sv
// Microsequencer model issuing condition fields
`timescale 1ns/10ps
module bcs_useq (
  input wire pclk,
  input wire [2:0] grp_req,
  input wire [3:0] pos_req,
  input wire new_ins,
  input wire branch_cond,
  output reg [2:0] cr_group_bits = 3'h0,
  output reg [3:0] cr_cond_pos = 4'h0,
  output reg first_ucycle = 1'b0,
  output reg taken = 1'b0
);
  // Issue a microinstruction, take its branch at the cycle end
  always @(posedge pclk) begin
    cr_group_bits <= grp_req;
    cr_cond_pos <= pos_req;
    first_ucycle <= new_ins;
    taken <= branch_cond;
  end
endmodule

// File: tb/branch_condition_select_test.sv
// Bench for the branch condition select block
`timescale 1ns/10ps
module branch_condition_select_test;
  reg pclk = 0, presetn = 0, penable = 0, psel = 0, pwrite = 0, new_ins = 0, alu_carry_out = 1;
  reg [2:0] grp_req = 3'h0, shift_carry = 3'h5; // Shift carries 1,0,1
  reg [3:0] pos_req = 4'h0;
  reg [7:0] paddr = 8'h00, opcode_latch = 8'h00, av = 8'h00, xv = 8'h00;
  reg [15:0] nv = 16'h0000, pt;
  reg [31:0] pwdata = 32'h0;
  wire [31:0] prdata, xlate_word = {28'h0, nv[7], 3'h3}; // Parity follows nv[7]
  wire [2:0] cr_group_bits;
  wire [3:0] cr_cond_pos;
  wire pready, pslverr, first_ucycle, branch_cond, final_carry, conv_sel_hi, conv_sel_lo;
  wire taken, index_test, prev_bus_sign, src_field_zero, io_halfword_dev, io_sync_test;
  wire mem_data_sign, alu_zero_n, alu_carry_n, alu_neg_n, alu_ovf_n, macro_irq_n;
  wire fp_instr_mask, mask_true, dst_field_zero, xy_bits_nonzero, mask_false, reloc_protect;
  wire shift_residue_flag, alu_z, alu_c, alu_n, alu_v, alu_link, alu_flag1, alu_flag2, alu_flag3;
  integer fails = 0, checked = 0, k, e, p, i, dv;
  assign {mem_data_sign, io_sync_test, io_halfword_dev} = nv[6:4];
  assign {src_field_zero, prev_bus_sign, index_test} = nv[2:0];
  assign {fp_instr_mask, macro_irq_n, alu_ovf_n, alu_neg_n, alu_carry_n, alu_zero_n} = nv[13:8];
  assign {shift_residue_flag, reloc_protect, mask_false} = xv[6:4];
  assign {xy_bits_nonzero, dst_field_zero, mask_true} = xv[2:0];
  assign {alu_flag3, alu_flag2, alu_flag1, alu_link, alu_v, alu_n, alu_c, alu_z} = av;
  bcs_top uut (.*);
  bcs_useq seq (.*);
  always #4 pclk = ~pclk;
  task test_done;
    begin
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task cmp(input [31:0] x, input [31:0] s, input [8*5:1] n);
    begin
      checked = checked + 1;
      if (s !== x) begin
        fails = fails + 1;
        $display("Error %0s expected %0h seen %0h", n, x, s);
      end
    end
  endtask
  // One APB transfer, released after the answering edge
  task apb(input w, input [7:0] a, input [31:0] d, input [31:0] x, input r);
    begin
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1;
      i = 0;
      do begin
        @(posedge pclk);
        i = i + 1;
      end while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1) begin
        fails = fails + 1;
        test_done;
      end
      if (!w) cmp(x, prdata, "rdata");
      cmp(r, pslverr, "err");
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
    end
  endtask
  // Microinstruction testing code p of group bits g
  task sel(input [2:0] g, input [3:0] p, input x);
    begin
      grp_req <= g;
      pos_req <= p;
      repeat (2) @(posedge pclk);
      #1 cmp(x, taken, "cond");
      @(posedge pclk);
    end
  endtask
  // Store decode word d at opcode o, start an instruction
  task ld(input [7:0] o, input [4:0] d, input f);
    begin
      apb(1, 8'h00, o, 0, 0);
      apb(0, 8'h00, 0, o, 0);
      apb(1, 8'h04, d, 0, 0);
      apb(0, 8'h04, 0, d, 0);
      opcode_latch <= o;
      new_ins <= 1;
      @(posedge pclk) new_ins <= 0;
      repeat (2) @(posedge pclk);
      cmp(d[1:0], {conv_sel_hi, conv_sel_lo}, "conv");
      cmp(f, final_carry, "carry");
    end
  endtask
  // Expected ALU group condition for status a at code c
  function fh(input [7:0] a, input [3:0] c);
    reg [15:0] v;
    begin
      v = {4'h0, a[7:4], a[2], a[0] | !a[1], a[1], 1'b0, a[3], a[0], a[2] ^ a[3], 1'b0};
      v[0] = v[1] | a[0];
      fh = v[c];
    end
  endfunction
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 8'h0C, 0, 0, 0);
    apb(0, 8'h10, 0, 0, 1);
    apb(1, 8'h08, 1, 0, 0);
    $display("register test done");
    for (k = 0; k < 2; k = k + 1) begin
      pt = k ? 16'h5A3C : 16'hA5C3;
      nv <= pt;
      for (p = 0; p < 14; p = p + 1)
        sel(p[0] ? 3'h6 : 3'h3, p, p == 3 || pt[p]);
    end
    $display("non-ALU test done");
    for (k = 0; k < 2; k = k + 1) begin
      apb(1, 8'h0C, k, 0, 0);
      apb(0, 8'h0C, 0, k, 0);
      pt = k ? 16'hC9 : 16'h36;
      xv <= pt;
      for (e = 0; e < 4; e = e + 1) begin
        dv = k * 16 + e * 5;
        ld(k * 4 + e, dv, k ? e % 2 == 0 : 1);
        sel(3'h3, 14, pt[e]);
        sel(3'h5, 15, pt[e + 4]);
        apb(0, 8'h08, 0, {16'h0, 4'hF, 3'h0, pt[e + 4], 3'h0, dv[4:0]}, 0);
      end
    end
    $display("extension test done");
    for (k = 0; k < 256; k = k + 1) begin
      av <= k;
      for (p = 0; p < 16; p = p + 1)
        sel(3'h7, p, fh(k, p));
    end
    $display("ALU test done");
    test_done;
  end
endmodule

// File: verilog/bcs_regs.vh
// Register offsets, field positions and reset values for the branch condition select block
`ifndef BCS_REGS_VH
`define BCS_REGS_VH

// APB byte offsets
`define BCS_OFS_STORE_ADDR 8'h00
`define BCS_OFS_STORE_DATA 8'h04
`define BCS_OFS_STATUS 8'h08
`define BCS_OFS_CTRL 8'h0C

// Decode word field positions
`define BCS_DEC_CONV_LO 0
`define BCS_DEC_CONV_HI 1
`define BCS_DEC_EXT_LO 2
`define BCS_DEC_EXT_HI 3
`define BCS_DEC_CARRY_SRC 4

// Status register field positions
`define BCS_ST_DEC_LSB 0
`define BCS_ST_COND 8
`define BCS_ST_GROUP 9
`define BCS_ST_POS_LSB 12

// Control register field positions
`define BCS_CTRL_SPARE 0

// Reset values
`define BCS_RST_DECODE 5'h00
`define BCS_RST_CTRL 1'b0
`define BCS_RST_ADDR 8'h00

// Extension select codes
`define BCS_EXT_A 2'h0
`define BCS_EXT_B 2'h1
`define BCS_EXT_C 2'h2

`endif

// File: verilog/bcs_top.v
// Branch condition select mux with opcode decode store and APB access
`timescale 1ns/10ps
`include "bcs_regs.vh"

module bcs_top #(
  parameter OPC_W = 8,
  parameter DEC_W = 5
) (
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Microinstruction fields
  input wire [2:0] cr_group_bits,
  input wire [3:0] cr_cond_pos,
  // Opcode decode control
  input wire [OPC_W-1:0] opcode_latch,
  input wire first_ucycle,
  // Non-ALU conditions
  input wire index_test,
  input wire prev_bus_sign,
  input wire src_field_zero,
  input wire io_halfword_dev,
  input wire io_sync_test,
  input wire mem_data_sign,
  input wire [31:0] xlate_word,
  input wire alu_zero_n,
  input wire alu_carry_n,
  input wire alu_neg_n,
  input wire alu_ovf_n,
  input wire macro_irq_n,
  input wire fp_instr_mask,
  input wire mask_true,
  input wire dst_field_zero,
  input wire xy_bits_nonzero,
  input wire mask_false,
  input wire reloc_protect,
  input wire shift_residue_flag,
  // ALU status register bits
  input wire alu_z,
  input wire alu_c,
  input wire alu_n,
  input wire alu_v,
  input wire alu_link,
  input wire alu_flag1,
  input wire alu_flag2,
  input wire alu_flag3,
  // Carry sources
  input wire alu_carry_out,
  input wire [2:0] shift_carry,
  // To the sequencer and condition code register
  output reg branch_cond,
  output reg final_carry,
  output reg conv_sel_hi,
  output reg conv_sel_lo
);

  // Constant one feeding the always-branch position
  localparam [0:0] CONST_ONE_BRANCH = 1'b1;

  // Opcode decode store, loaded by software
  reg [DEC_W-1:0] decode_store [0:(1<<OPC_W)-1];

  // Captured decode word for the current instruction
  reg [DEC_W-1:0] decode_q;
  // Store address pointer for software access
  reg [OPC_W-1:0] store_addr_q;
  // Level driven on the spare extension positions
  reg spare_q;
  // Last presented condition and its position, for status reads
  reg last_cond_q;
  reg last_group_q;
  reg [3:0] last_pos_q;

  // Derived selects
  wire group_sel;
  wire ext_sel_hi;
  wire ext_sel_lo;
  wire [1:0] ext_sel;
  wire carry_src_shift;
  wire xlate_parity;
  wire [DEC_W-1:0] decode_d;
  wire alu_cond_out;
  wire cond_select_mux;

  // APB phase decode
  wire apb_access;
  wire apb_done;

  // Odd parity over the translator word
  assign xlate_parity = ^xlate_word;

  // Group select from three control bits
  assign group_sel = &cr_group_bits;

  // Decode store lookup by opcode latch
  assign decode_d = decode_store[opcode_latch];

  // Decode word fields
  assign ext_sel_hi = decode_q[`BCS_DEC_EXT_HI];
  assign ext_sel_lo = decode_q[`BCS_DEC_EXT_LO];
  assign ext_sel = {ext_sel_hi, ext_sel_lo};
  assign carry_src_shift = decode_q[`BCS_DEC_CARRY_SRC];

  // ALU condition group select
  function alu_pick;
    input [3:0] pos;
    input z;
    input c;
    input n;
    input v;
    input lk;
    input f1;
    input f2;
    input f3;
    begin
      case (pos)
        4'h0: alu_pick = (n ^ v) | z;
        4'h1: alu_pick = n ^ v;
        4'h2: alu_pick = z;
        4'h3: alu_pick = v;
        4'h4: alu_pick = 1'b0;
        4'h5: alu_pick = c;
        4'h6: alu_pick = z | ~c;
        4'h7: alu_pick = n;
        4'h8: alu_pick = lk;
        4'h9: alu_pick = f1;
        4'hA: alu_pick = f2;
        4'hB: alu_pick = f3;
        // Codes above eleven are unused and present zero
        default: alu_pick = 1'b0;
      endcase
    end
  endfunction

  assign alu_cond_out = alu_pick(cr_cond_pos, alu_z, alu_c, alu_n, alu_v,
                                 alu_link, alu_flag1, alu_flag2, alu_flag3);

  // Four-way choice used by extension positions and shift carry
  function pick4;
    input [1:0] sel;
    input a;
    input b;
    input c;
    input d;
    begin
      case (sel)
        `BCS_EXT_A: pick4 = a;
        `BCS_EXT_B: pick4 = b;
        `BCS_EXT_C: pick4 = c;
        default: pick4 = d;
      endcase
    end
  endfunction

  // Sixteen non-ALU positions, in position order
  wire [15:0] misc_src;
  assign misc_src[0] = index_test;
  assign misc_src[1] = prev_bus_sign;
  assign misc_src[2] = src_field_zero;
  assign misc_src[3] = CONST_ONE_BRANCH;
  assign misc_src[4] = io_halfword_dev;
  assign misc_src[5] = io_sync_test;
  assign misc_src[6] = mem_data_sign;
  assign misc_src[7] = xlate_parity;
  assign misc_src[8] = alu_zero_n;
  assign misc_src[9] = alu_carry_n;
  assign misc_src[10] = alu_neg_n;
  assign misc_src[11] = alu_ovf_n;
  assign misc_src[12] = macro_irq_n;
  assign misc_src[13] = fp_instr_mask;
  // Position 14 extension; spare code drives the control level
  assign misc_src[14] = pick4(ext_sel, mask_true, dst_field_zero,
                              xy_bits_nonzero, spare_q);
  // Position 15 extension; spare code drives the control level
  assign misc_src[15] = pick4(ext_sel, mask_false, reloc_protect,
                              shift_residue_flag, spare_q);

  // Final condition selected by group and position
  assign cond_select_mux = group_sel ? alu_cond_out : misc_src[cr_cond_pos];

  // Condition and carry reach the sequencer within the microcycle
  always @* begin
    branch_cond = cond_select_mux;
    if (carry_src_shift) begin
      // Shift register carry picked by the extension bits; code 11 unused
      final_carry = pick4(ext_sel, shift_carry[0], shift_carry[1],
                          shift_carry[2], 1'b0);
    end else begin
      final_carry = alu_carry_out;
    end
  end

  // Decode register loads at instruction start and holds otherwise
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      decode_q <= `BCS_RST_DECODE;
    end else if (first_ucycle) begin
      decode_q <= decode_d;
    end
  end

  // Conversion method selects sent to the condition code register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_sel_hi <= 1'b0;
      conv_sel_lo <= 1'b0;
    end else if (first_ucycle) begin
      conv_sel_hi <= decode_d[`BCS_DEC_CONV_HI];
      conv_sel_lo <= decode_d[`BCS_DEC_CONV_LO];
    end
  end

  // Snapshot of the presented condition for software
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_cond_q <= 1'b0;
      last_group_q <= 1'b0;
      last_pos_q <= 4'h0;
    end else begin
      last_cond_q <= cond_select_mux;
      last_group_q <= group_sel;
      last_pos_q <= cr_cond_pos;
    end
  end

  // APB access phase and its completing edge
  assign apb_access = psel & penable;
  assign apb_done = apb_access & pready;

  // One wait state: ready rises in the second access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= apb_access & ~pready;
    end
  end

  // Address match test for mapped registers
  function addr_mapped;
    input [7:0] a;
    begin
      addr_mapped = (a == `BCS_OFS_STORE_ADDR) || (a == `BCS_OFS_STORE_DATA) ||
                    (a == `BCS_OFS_STATUS) || (a == `BCS_OFS_CTRL);
    end
  endfunction

  // Read data and error answer, prepared while ready is low
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (apb_access & ~pready) begin
      pslverr <= ~addr_mapped(paddr);
      prdata <= 32'h00000000;
      if (!pwrite) begin
        case (paddr)
          `BCS_OFS_STORE_ADDR: begin
            prdata[OPC_W-1:0] <= store_addr_q;
          end
          `BCS_OFS_STORE_DATA: begin
            prdata[DEC_W-1:0] <= decode_store[store_addr_q];
          end
          `BCS_OFS_STATUS: begin
            prdata[`BCS_ST_DEC_LSB+DEC_W-1:`BCS_ST_DEC_LSB] <= decode_q;
            prdata[`BCS_ST_COND] <= last_cond_q;
            prdata[`BCS_ST_GROUP] <= last_group_q;
            prdata[`BCS_ST_POS_LSB+3:`BCS_ST_POS_LSB] <= last_pos_q;
          end
          `BCS_OFS_CTRL: begin
            prdata[`BCS_CTRL_SPARE] <= spare_q;
          end
          // Unmapped reads return zero with an error
          default: begin
            prdata <= 32'h00000000;
          end
        endcase
      end
    end else if (!apb_access) begin
      pslverr <= 1'b0;
    end
  end

  // Register writes take effect at the completing edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      store_addr_q <= `BCS_RST_ADDR;
      spare_q <= `BCS_RST_CTRL;
    end else if (apb_done & pwrite) begin
      case (paddr)
        `BCS_OFS_STORE_ADDR: begin
          store_addr_q <= pwdata[OPC_W-1:0];
        end
        `BCS_OFS_CTRL: begin
          spare_q <= pwdata[`BCS_CTRL_SPARE];
        end
        // Other offsets carry no writable state here
        default: begin
          spare_q <= spare_q;
        end
      endcase
    end
  end

  // Decode store contents written by software, no reset
  always @(posedge pclk) begin
    if (apb_done & pwrite & (paddr == `BCS_OFS_STORE_DATA)) begin
      decode_store[store_addr_q] <= pwdata[DEC_W-1:0];
    end
  end

endmodule
